// ### hdl/fpuex_pkg.sv
// shared constants, register map and carrier types of the fpu error exception block
package fpuex_pkg;
   localparam int unsigned ERR_CLASSES = 6;
   localparam int unsigned STATUS_W = 8;
   localparam int unsigned IRQ_W = 3;
   // status bit positions; the six class bits are shared with the mask word
   localparam int unsigned BIT_INVALID = 0;
   localparam int unsigned BIT_DENORMAL = 1;
   localparam int unsigned BIT_ZERO_DIV = 2;
   localparam int unsigned BIT_OVERFLOW = 3;
   localparam int unsigned BIT_UNDERFLOW = 4;
   localparam int unsigned BIT_INEXACT = 5;
   localparam int unsigned BIT_STACK_FAULT = 6;
   localparam int unsigned BIT_SUMMARY = 7;
   // interrupt status bit positions
   localparam int unsigned IRQ_BIT_FPU_FAULT = 0;
   localparam int unsigned IRQ_BIT_SIMD_FAULT = 1;
   localparam int unsigned IRQ_BIT_PENDING = 2;
   // register byte offsets
   localparam logic [7:0] OFS_PRIMARY_CTRL = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_ERR_PTR = 8'h0c;
   localparam logic [7:0] OFS_SAVED_PTR = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;
   localparam logic [7:0] OFS_FAULT_INFO = 8'h20;
   localparam int unsigned NE_BIT = 0;
   // reset values
   localparam logic RST_NE = 1'b0;
   localparam logic [ERR_CLASSES-1:0] RST_MASK = 6'h3f;
   localparam logic [IRQ_W-1:0] RST_IRQ_ENABLE = 3'h0;
   // fault vectors
   localparam logic [7:0] VEC_FPU_ERROR = 8'h10;
   localparam logic [7:0] VEC_SIMD_FP = 8'h13;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      KIND_FP_WAITING = 4'h0,
      KIND_WAIT = 4'h1,
      KIND_INIT = 4'h2,
      KIND_CLEAR_EXC = 4'h3,
      KIND_STORE_STATUS = 4'h4,
      KIND_STORE_CTRL = 4'h5,
      KIND_STORE_ENV = 4'h6,
      KIND_SAVE_STATE = 4'h7,
      KIND_EXT_SAVE = 4'h8,
      KIND_EXT_RESTORE = 4'h9,
      KIND_OTHER = 4'hf
   } fpuex_kind_type;

   typedef struct packed {
      logic [ERR_CLASSES-1:0] flags;
      logic stack_fault;
      logic [31:0] instr_ptr;
   } fpuex_err_type;

   typedef struct packed {
      fpuex_kind_type kind;
      logic [31:0] instr_ptr;
   } fpuex_instr_type;

   typedef struct packed {
      logic [7:0] vector;
      logic has_error_code;
      logic [31:0] saved_ip;
   } fpuex_fault_type;
endpackage

// ### hdl/fpuex_sticky.sv
// sticky flag vector in which a set wins over a simultaneous clear
`timescale 1ns/1ps
module fpuex_sticky #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] q
);
   if (WIDTH < 1) begin : g_width_check
      $error("fpuex_sticky: WIDTH must be at least 1");
   end

   wire logic [WIDTH-1:0] next_q = (q & ~clr) | set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule // fpuex_sticky

// ### hdl/fpuex_top.sv
// fpu error exception unit: flags, masks, deferred fault and axi4-lite registers
`timescale 1ns/1ps
// Overview of operation
// - detect six error classes plus the stack subtype of invalid
// - one sticky flag and mask per class
// - masked errors take default result, no fault
// - vector 16 fault only with enable set
// - set flag, hold pending, fault at wait
// - waiting instructions deliver pending error first
// - non-waiting instructions skip pending error check
// - extended save and restore skip pending errors
// - fault carries no error code
// - saved pointer names the waiting instruction
// - faulting instruction address kept in unit
// - error information retained for later recovery
// - wait instruction forces delivery before dependents
// - simd errors use vector 19 instead
module fpuex_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic err_valid,
   input wire fpuex_pkg::fpuex_err_type err_event,
   input wire logic simd_err_valid,
   input wire logic [31:0] simd_err_ptr,
   input wire logic instr_valid,
   input wire fpuex_pkg::fpuex_instr_type instr_req,
   output logic instr_done,
   output logic instr_executed,
   output logic [15:0] instr_result,
   output logic default_used,
   output logic fault_valid,
   output fpuex_pkg::fpuex_fault_type fault_info,
   output logic irq
);
   import fpuex_pkg::*;

   // the status word packs the classes, the stack subtype, then the pending summary
   if (STATUS_W != ERR_CLASSES + 2) begin : g_status_w
      $error("fpuex_top: status width does not fit the classes");
   end
   if (BIT_STACK_FAULT != ERR_CLASSES) begin : g_stack_bit
      $error("fpuex_top: stack subtype must follow the classes");
   end
   if (BIT_SUMMARY != STATUS_W - 1) begin : g_summary_bit
      $error("fpuex_top: summary must be the top status bit");
   end
   // read and result words zero-fill fixed widths, so the counts are fixed too
   if (ERR_CLASSES != 6 || IRQ_W != 3) begin : g_counts
      $error("fpuex_top: six classes and three interrupt events expected");
   end

   // register state
   logic numeric_error_enable;
   logic [ERR_CLASSES-1:0] mask;
   logic [STATUS_W-1:0] status;
   logic [31:0] err_ptr;
   logic [31:0] saved_ptr;
   logic [7:0] last_vector;
   logic pending;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_enable;

   // axi write channel state
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire logic aw_take = s_axi_awvalid & s_axi_awready;
   wire logic w_take = s_axi_wvalid & s_axi_wready;
   wire logic wr_fire = aw_held & w_held & ~s_axi_bvalid;
   wire logic wr_lane0 = wr_fire & w_strb[0];
   wire logic wr_ctrl = wr_lane0 & (aw_addr == OFS_PRIMARY_CTRL);
   wire logic wr_mask = wr_lane0 & (aw_addr == OFS_MASK);
   wire logic wr_irq_clr = wr_lane0 & (aw_addr == OFS_IRQ_CLEAR);
   wire logic wr_irq_en = wr_lane0 & (aw_addr == OFS_IRQ_ENABLE);
   wire logic wr_mapped = (aw_addr == OFS_PRIMARY_CTRL) | (aw_addr == OFS_MASK)
                        | (aw_addr == OFS_IRQ_CLEAR) | (aw_addr == OFS_IRQ_ENABLE)
                        | (aw_addr == OFS_STATUS) | (aw_addr == OFS_ERR_PTR)
                        | (aw_addr == OFS_SAVED_PTR) | (aw_addr == OFS_IRQ_STATUS)
                        | (aw_addr == OFS_FAULT_INFO);
   wire logic ar_take = s_axi_arvalid & s_axi_arready;

   // error detection and classification
   // only the six class bits are meaningful; the stack subtype rides on invalid
   wire logic [ERR_CLASSES-1:0] err_classes = err_valid ? err_event.flags : '0;
   wire logic err_stack = err_valid & err_event.stack_fault
                        & err_event.flags[BIT_INVALID];
   wire logic [ERR_CLASSES-1:0] err_unmasked = err_classes & ~mask;
   wire logic err_any_masked = |(err_classes & mask);
   wire logic err_any_unmasked = |err_unmasked;
   // only an unmasked error under the enable arms a deferred fault
   wire logic pend_set = err_any_unmasked & numeric_error_enable;

   // instruction classification
   wire logic is_waiting = instr_valid
                         & ((instr_req.kind == KIND_FP_WAITING)
                         | (instr_req.kind == KIND_WAIT));
   wire logic is_init = instr_valid & (instr_req.kind == KIND_INIT);
   wire logic is_clear = instr_valid & (instr_req.kind == KIND_CLEAR_EXC);
   // non-waiting and extended state instructions never look at pending
   wire logic deliver = is_waiting & pending;
   wire logic flags_clear = is_init | is_clear;

   // status word: sticky flags, set wins over clear
   wire logic [STATUS_W-1:0] status_set = {1'b0, err_stack, err_classes};
   wire logic [STATUS_W-1:0] status_clr = flags_clear ? {STATUS_W{1'b1}} : '0;
   logic [STATUS_W-2:0] status_flags;

   fpuex_sticky #(
      .WIDTH(STATUS_W-1)
   ) u_status_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(status_set[STATUS_W-2:0]),
      .clr(status_clr[STATUS_W-2:0]),
      .q(status_flags)
   );

   // summary bit mirrors the deferred error so software sees it armed
   wire logic [STATUS_W-1:0] status_word = {pending, status_flags};

   // pending error: a new error wins over a clear or delivery
   wire logic pend_clr = deliver | flags_clear;
   wire logic next_pending = (pending & ~pend_clr) | pend_set;

   // interrupt events
   // the simd event keeps its own bit so software can tell the two vectors apart
   wire logic [IRQ_W-1:0] irq_set;
   assign irq_set[IRQ_BIT_FPU_FAULT] = deliver;
   assign irq_set[IRQ_BIT_SIMD_FAULT] = simd_err_valid;
   assign irq_set[IRQ_BIT_PENDING] = pend_set;
   wire logic [IRQ_W-1:0] irq_clr = wr_irq_clr ? w_data[IRQ_W-1:0] : '0;

   fpuex_sticky #(
      .WIDTH(IRQ_W)
   ) u_irq_status (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(irq_set),
      .clr(irq_clr),
      .q(irq_status)
   );

   wire logic next_irq = |(irq_status & irq_enable);

   // fault delivery selection
   // a simd error never borrows the fpu error vector; fpu delivery has priority
   wire logic fault_fire = deliver | simd_err_valid;
   wire logic [7:0] next_vector = deliver ? VEC_FPU_ERROR : VEC_SIMD_FP;
   wire logic [31:0] next_saved_ip = deliver ? instr_req.instr_ptr : simd_err_ptr;

   // instruction results
   wire logic [15:0] status_result = {8'h00, status_word};
   wire logic [15:0] ctrl_result = {10'h000, mask};
   wire logic [15:0] next_result = (instr_req.kind == KIND_STORE_STATUS) ? status_result
                                 : (instr_req.kind == KIND_STORE_CTRL) ? ctrl_result
                                 : 16'h0000;

   // read decode
   wire logic [31:0] rd_ctrl = {31'h00000000, numeric_error_enable};
   wire logic [31:0] rd_mask = {26'h0000000, mask};
   wire logic [31:0] rd_status = {24'h000000, status_word};
   wire logic [31:0] rd_irq_st = {29'h00000000, irq_status};
   wire logic [31:0] rd_irq_en = {29'h00000000, irq_enable};
   wire logic [31:0] rd_fault = {24'h000000, last_vector};
   wire logic rd_hit_ctrl = (s_axi_araddr == OFS_PRIMARY_CTRL);
   wire logic rd_hit_mask = (s_axi_araddr == OFS_MASK);
   wire logic rd_hit_status = (s_axi_araddr == OFS_STATUS);
   wire logic rd_hit_eptr = (s_axi_araddr == OFS_ERR_PTR);
   wire logic rd_hit_sptr = (s_axi_araddr == OFS_SAVED_PTR);
   wire logic rd_hit_irq_st = (s_axi_araddr == OFS_IRQ_STATUS);
   wire logic rd_hit_irq_clr = (s_axi_araddr == OFS_IRQ_CLEAR);
   wire logic rd_hit_irq_en = (s_axi_araddr == OFS_IRQ_ENABLE);
   wire logic rd_hit_fault = (s_axi_araddr == OFS_FAULT_INFO);
   wire logic rd_mapped = rd_hit_ctrl | rd_hit_mask | rd_hit_status | rd_hit_eptr
                        | rd_hit_sptr | rd_hit_irq_st | rd_hit_irq_clr
                        | rd_hit_irq_en | rd_hit_fault;
   // the clear register is write-only and reads as zero
   wire logic [31:0] next_rdata = rd_hit_ctrl ? rd_ctrl
                                : rd_hit_mask ? rd_mask
                                : rd_hit_status ? rd_status
                                : rd_hit_eptr ? err_ptr
                                : rd_hit_sptr ? saved_ptr
                                : rd_hit_irq_st ? rd_irq_st
                                : rd_hit_irq_en ? rd_irq_en
                                : rd_hit_fault ? rd_fault
                                : 32'h00000000;

   // axi write path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         // ready drops once a beat is held, so a second beat is never lost
         s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
         s_axi_wready <= ~w_held & ~w_take & ~s_axi_bvalid;
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         numeric_error_enable <= RST_NE;
         mask <= RST_MASK;
         irq_enable <= RST_IRQ_ENABLE;
      end else begin
         if (wr_ctrl) begin
            numeric_error_enable <= w_data[NE_BIT];
         end
         // initialise restores full masking; a software write in the same cycle wins
         if (wr_mask) begin
            mask <= w_data[ERR_CLASSES-1:0];
         end else if (is_init) begin
            mask <= RST_MASK;
         end
         if (wr_irq_en) begin
            irq_enable <= w_data[IRQ_W-1:0];
         end
      end
   end

   // error recovery information
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending <= 1'b0;
         err_ptr <= 32'h00000000;
      end else begin
         pending <= next_pending;
         // the address of the causing instruction stays until the next unmasked error,
         // so a handler entered later still finds it
         if (err_any_unmasked) begin
            err_ptr <= err_event.instr_ptr;
         end
      end
   end

   // fault delivery towards the core
   // fault_info holds until the next fault, so the core may read it late
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_valid <= 1'b0;
         fault_info <= '0;
         saved_ptr <= 32'h00000000;
         last_vector <= 8'h00;
      end else begin
         fault_valid <= fault_fire;
         if (fault_fire) begin
            fault_info.vector <= next_vector;
            fault_info.has_error_code <= 1'b0;
            fault_info.saved_ip <= next_saved_ip;
            saved_ptr <= next_saved_ip;
            last_vector <= next_vector;
         end
      end
   end

   // instruction completion and masked responses
   // done pulses for every instruction, whether it ran or was replaced
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_done <= 1'b0;
         instr_executed <= 1'b0;
         instr_result <= 16'h0000;
         default_used <= 1'b0;
      end else begin
         instr_done <= instr_valid;
         // a delivered fault cancels the waiting instruction before it runs
         instr_executed <= instr_valid & ~deliver;
         instr_result <= instr_valid ? next_result : 16'h0000;
         // masked classes continue with the default response, even beside unmasked ones
         default_used <= err_any_masked;
      end
   end

   // the level follows the sticky bits one cycle late, so the pin never glitches
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end
endmodule // fpuex_top

// ### tb/fpuex_props.sv
// assertion checker bound to the fpu error exception top
`timescale 1ns/1ps
module fpuex_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic err_valid,
   input wire logic simd_err_valid,
   input wire logic [31:0] simd_err_ptr,
   input wire logic instr_valid,
   input wire fpuex_pkg::fpuex_instr_type instr_req,
   input wire logic instr_done,
   input wire logic instr_executed,
   input wire logic default_used,
   input wire logic fault_valid,
   input wire fpuex_pkg::fpuex_fault_type fault_info
);
   import fpuex_pkg::*;
   wire logic fpu_f = fault_valid && fault_info.vector == VEC_FPU_ERROR;
   wire logic wait_k = instr_req.kind inside {KIND_FP_WAITING, KIND_WAIT};
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_nonwait_runs:
      assert property (instr_valid && !wait_k |=> instr_done && instr_executed)
      else $error("non-waiting instruction did not run");
   a_fault_cause:
      assert property (fpu_f |-> $past(instr_valid) && $past(wait_k))
      else $error("fpu fault without a waiting instruction");
   a_fault_replaces:
      assert property (fpu_f |-> instr_done && !instr_executed)
      else $error("faulting instruction still executed");
   a_no_err_code:
      assert property (fault_valid |-> !fault_info.has_error_code)
      else $error("fault carries an error code");
   a_saved_ptr:
      assert property (fpu_f |-> fault_info.saved_ip == $past(instr_req.instr_ptr))
      else $error("saved pointer is not the waiting instruction");
   a_simd_vector:
      assert property (fault_valid && !fpu_f |-> fault_info.vector == VEC_SIMD_FP
         && $past(simd_err_valid))
      else $error("unexpected fault vector");
   a_simd_prompt:
      assert property (simd_err_valid && !(instr_valid && wait_k) |=> fault_valid
         && fault_info.saved_ip == $past(simd_err_ptr))
      else $error("simd fault not delivered");
   a_default_cause:
      assert property (default_used |-> $past(err_valid))
      else $error("default response without an error");
   c_fpu_fault: cover property (fpu_f);
   c_simd_fault: cover property (fault_valid && !fpu_f);
   c_default: cover property (default_used);
endmodule // fpuex_props

bind fpuex_top fpuex_props props_i (.aclk(aclk), .aresetn(aresetn), .err_valid(err_valid),
   .simd_err_valid(simd_err_valid), .simd_err_ptr(simd_err_ptr), .instr_valid(instr_valid),
   .instr_req(instr_req), .instr_done(instr_done), .instr_executed(instr_executed),
   .default_used(default_used), .fault_valid(fault_valid), .fault_info(fault_info));

// ### tb/fpuex_core_model.sv
// core and datapath stand-in: feeds errors and instructions, samples the answers
`timescale 1ns/1ps
module fpuex_core_model (
   input wire logic aclk,
   output logic err_valid,
   output fpuex_pkg::fpuex_err_type err_event,
   output logic simd_err_valid,
   output logic [31:0] simd_err_ptr,
   output logic instr_valid,
   output fpuex_pkg::fpuex_instr_type instr_req,
   input wire logic instr_done,
   input wire logic instr_executed,
   input wire logic [15:0] instr_result,
   input wire logic default_used,
   input wire logic fault_valid,
   input wire fpuex_pkg::fpuex_fault_type fault_info
);
   import fpuex_pkg::*;
   logic got_done, got_exec, got_dflt, got_fault;
   logic [15:0] got_res;
   fpuex_fault_type got_info;
   initial begin
      err_valid = 1'h0;
      err_event = '0;
      simd_err_valid = 1'h0;
      simd_err_ptr = '0;
      instr_valid = 1'h0;
      instr_req = '0;
   end
   // answers stand one cycle, so they are taken just after the edge that follows a request
   task automatic take();
      #1;
      got_done = instr_done;
      got_exec = instr_executed;
      got_res = instr_result;
      got_dflt = default_used;
      got_fault = fault_valid;
      got_info = fault_info;
   endtask
   // idle payloads show the inverse, so a stale value never looks like a fresh request
   task automatic issue(input fpuex_kind_type k, input logic [31:0] p);
      @(posedge aclk);
      instr_valid <= 1'h1;
      instr_req <= '{k, p};
      @(posedge aclk);
      instr_valid <= 1'h0;
      instr_req <= ~instr_req;
      take();
   endtask
   // bit 6 of f carries the stack subtype beside the six class bits
   task automatic raise(input logic [6:0] f, input logic [31:0] p);
      @(posedge aclk);
      err_valid <= 1'h1;
      err_event <= '{f[5:0], f[6], p};
      @(posedge aclk);
      err_valid <= 1'h0;
      err_event <= ~err_event;
      take();
   endtask
   task automatic simd(input logic [31:0] p);
      @(posedge aclk);
      simd_err_valid <= 1'h1;
      simd_err_ptr <= p;
      @(posedge aclk);
      simd_err_valid <= 1'h0;
      simd_err_ptr <= ~simd_err_ptr;
      take();
   endtask
endmodule // fpuex_core_model

// ### tb/fpuex_top_bench.sv
// self-checking bench for the fpu error exception unit
`timescale 1ns/1ps
module fpuex_top_bench;
   import fpuex_pkg::*;
   typedef struct packed {
      logic [5:0] mask;
      logic [5:0] flags;
      fpuex_kind_type kind;
   } fpuex_row_type;
   // each row raises one error under its mask, then runs one instruction of its kind
   localparam fpuex_row_type ROWS [14] = '{
      '{6'h3f, 6'h04, KIND_FP_WAITING}, '{6'h3b, 6'h04, KIND_FP_WAITING},
      '{6'h3b, 6'h04, KIND_WAIT}, '{6'h3e, 6'h01, KIND_INIT},
      '{6'h3e, 6'h01, KIND_CLEAR_EXC}, '{6'h3e, 6'h01, KIND_STORE_STATUS},
      '{6'h3e, 6'h01, KIND_STORE_CTRL}, '{6'h3e, 6'h01, KIND_STORE_ENV},
      '{6'h3e, 6'h01, KIND_SAVE_STATE}, '{6'h3e, 6'h01, KIND_EXT_SAVE},
      '{6'h37, 6'h08, KIND_EXT_RESTORE}, '{6'h2f, 6'h10, KIND_OTHER},
      '{6'h1f, 6'h3f, KIND_WAIT}, '{6'h3d, 6'h02, KIND_FP_WAITING}};
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd, simd_err_ptr;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, fault_valid, pend, wait_k, clr_k;
   logic err_valid, simd_err_valid, instr_valid, instr_done, instr_executed, default_used;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] instr_result;
   fpuex_err_type err_event;
   fpuex_instr_type instr_req;
   fpuex_fault_type fault_info;
   fpuex_row_type r;
   int mismatches = 0, comparisons = 0;
   always #2 aclk = ~aclk;
   fpuex_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .err_valid(err_valid), .err_event(err_event), .simd_err_valid(simd_err_valid),
      .simd_err_ptr(simd_err_ptr), .instr_valid(instr_valid), .instr_req(instr_req),
      .instr_done(instr_done), .instr_executed(instr_executed), .instr_result(instr_result),
      .default_used(default_used), .fault_valid(fault_valid), .fault_info(fault_info),
      .irq(irq));
   fpuex_core_model core (.aclk(aclk), .err_valid(err_valid), .err_event(err_event),
      .simd_err_valid(simd_err_valid), .simd_err_ptr(simd_err_ptr),
      .instr_valid(instr_valid), .instr_req(instr_req), .instr_done(instr_done),
      .instr_executed(instr_executed), .instr_result(instr_result),
      .default_used(default_used), .fault_valid(fault_valid), .fault_info(fault_info));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
      chk(n, e, rd);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // a full run needs well under 2000 cycles
   initial begin
      repeat (6000) @(posedge aclk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rchk("mask reset", OFS_MASK, 32'h3f);
      rchk("ctrl reset", OFS_PRIMARY_CTRL, 32'h0);
      rchk("unmapped read", 8'h40, 32'h0);
      chk("unmapped rresp", RESP_SLVERR, rs);
      axi_wr(8'h40, 32'h1);
      chk("unmapped bresp", RESP_SLVERR, rs);
      axi_wr(OFS_MASK, 32'h3b);
      core.raise(6'h04, 32'h500);
      rchk("status", OFS_STATUS, 32'h04);
      core.issue(KIND_WAIT, 32'h504);
      chk("fault", 1'h0, core.got_fault);
      core.issue(KIND_INIT, 32'h0);
      axi_wr(OFS_PRIMARY_CTRL, 32'h1);
      foreach (ROWS[i]) begin
         r = ROWS[i];
         pend = |(r.flags & ~r.mask);
         wait_k = r.kind inside {KIND_FP_WAITING, KIND_WAIT};
         clr_k = r.kind inside {KIND_INIT, KIND_CLEAR_EXC};
         axi_wr(OFS_MASK, {26'h0, r.mask});
         core.raise(r.flags, 32'h1000 + i);
         chk("default_used", |(r.flags & r.mask), core.got_dflt);
         rchk("status", OFS_STATUS, 32'({pend, 1'h0, r.flags}));
         core.issue(r.kind, 32'h2000 + i);
         chk("done", 1'h1, core.got_done);
         chk("fault", pend && wait_k, core.got_fault);
         chk("executed", !(pend && wait_k), core.got_exec);
         if (r.kind == KIND_STORE_STATUS) chk("word", {pend, 1'h0, r.flags}, core.got_res);
         if (r.kind == KIND_STORE_CTRL) chk("word", r.mask, core.got_res);
         if (pend && wait_k) chk("saved", 32'h2000 + i, core.got_info.saved_ip);
         if (pend && wait_k) chk("vector", VEC_FPU_ERROR, core.got_info.vector);
         if (pend) rchk("err ptr", OFS_ERR_PTR, 32'h1000 + i);
         core.issue(KIND_WAIT, 32'h3000 + i);
         chk("wait fault", pend && !wait_k && !clr_k, core.got_fault);
         core.issue(KIND_INIT, 32'h0);
      end
      core.raise(7'h40, 32'h600);
      core.raise(7'h41, 32'h601);
      rchk("stack", OFS_STATUS, 32'h41);
      core.issue(KIND_INIT, 32'h0);
      axi_wr(OFS_IRQ_CLEAR, 32'h7);
      axi_wr(OFS_IRQ_ENABLE, 32'h1);
      axi_wr(OFS_MASK, 32'h3b);
      core.raise(6'h04, 32'h700);
      core.issue(KIND_FP_WAITING, 32'h704);
      rchk("kept", OFS_STATUS, 32'h04);
      rchk("irq status", OFS_IRQ_STATUS, 32'h5);
      #1 chk("irq", 1'h1, irq);
      axi_wr(OFS_IRQ_CLEAR, 32'h1);
      rchk("irq status", OFS_IRQ_STATUS, 32'h4);
      #1 chk("irq", 1'h0, irq);
      core.simd(32'h900);
      chk("simd fault", 1'h1, core.got_fault);
      chk("vector", VEC_SIMD_FP, core.got_info.vector);
      chk("simd ip", 32'h900, core.got_info.saved_ip);
      rchk("irq status", OFS_IRQ_STATUS, 32'h6);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rchk("mask after reset", OFS_MASK, 32'h3f);
      rchk("status after reset", OFS_STATUS, 32'h0);
      rchk("ctrl after reset", OFS_PRIMARY_CTRL, 32'h0);
      report_and_stop();
   end
endmodule // fpuex_top_bench
